// [logic/prio_map_params.svh]
// Offsets, field positions, reset values and encodings for the priority tag queue mapper.
`ifndef PRIO_MAP_PARAMS_SVH
`define PRIO_MAP_PARAMS_SVH

// Register offsets on the switch control register port.
`define LOWER_MAP_ADDR 8'h80
`define UPPER_MAP_ADDR 8'h81
`define THRESH_CTRL_ADDR 8'h82

// Reset values of the two mapping registers, built from their 2-bit fields.
`define LOWER_MAP_RESET 8'h50
`define UPPER_MAP_RESET 8'hfa

// Two-queue threshold field position and reset value.
`define THRESH_MSB 7
`define THRESH_LSB 6
`define THRESH_RESET 2'h2

// Read-only reserved bits 5 to 0 of the threshold register read back their fixed values.
`define THRESH_RSVD_VALUE 6'h04

// Width of one mapping field and of a priority code.
`define MAP_FIELD_W 2
`define PRIO_CODE_W 3

// Answer to a read of an unmapped offset.
`define UNMAPPED_RDATA 8'h00

// Queue results.
`define QUEUE_LOW 2'h0
`define QUEUE_HIGH 2'h1
`define RESULT_TOP 2'h3
`define RESULT_ONE 2'h1
`define RESULT_TWO 2'h2

`endif

// [logic/prio_map_pkg.sv]
// Types shared by the priority tag queue mapper modules.
`default_nettype none
package prio_map_pkg;

    typedef logic [1:0] prio2_t;
    typedef logic [2:0] prio_code_t;
    typedef logic [7:0] reg_byte_t;
    typedef logic [7:0] reg_addr_t;

    // Whole state of the top module.
    typedef struct packed {
        reg_byte_t lower_map_reg;
        reg_byte_t upper_map_reg;
        prio2_t two_queue_threshold_reg;
        reg_byte_t rdata_reg;
        logic queue_valid_reg;
        prio2_t queue_idx_reg;
        prio2_t mapped_prio_reg;
    } mapper_state_s;

endpackage
`default_nettype wire

// [logic/priority_tag_queue_mapper.sv]
// Priority tag to queue mapper with its three control registers.
`timescale 1ns/100ps
`default_nettype none
`include "prio_map_params.svh"

module priority_tag_queue_mapper (
    input wire logic I_CLOCK, // Core clock, 200 MHz.
    input wire logic I_RST_B, // Synchronous reset, active low.
    input wire prio_map_pkg::reg_addr_t I_REG_ADDR, // Register offset.
    input wire logic I_REG_WR, // Write strobe, one cycle.
    input wire prio_map_pkg::reg_byte_t I_REG_WDATA, // Write data.
    input wire logic I_REG_RD, // Read strobe, one cycle.
    output logic [7:0] O_REG_RDATA, // Read data, valid the cycle after the strobe.
    input wire logic I_FRAME_VALID, // A frame asks for a queue.
    input wire prio_map_pkg::prio_code_t I_PRIO_CODE, // Tag priority code.
    input wire logic I_USE_SERVICE, // Take the service-field result instead of the tag.
    input wire prio_map_pkg::prio2_t I_SERVICE_RESULT, // Service-field mapped result.
    input wire logic I_TWO_QUEUE, // Two-queue configuration selected.
    output logic O_QUEUE_VALID, // Queue answer valid, one cycle.
    output logic [1:0] O_QUEUE_IDX, // Chosen queue.
    output logic [1:0] O_MAPPED_PRIO // 2-bit mapped result before reduction.
);
    import prio_map_pkg::*;

    mapper_state_s state_reg;
    mapper_state_s state_next;
    prio2_t tag_result;
    prio2_t chosen_result;

    queue_reduce_if rif ();

    queue_reducer u_reducer (
        .rif(rif)
    );

    // Pick the 2-bit field for a priority code out of the two mapping bytes.
    function automatic prio2_t map_field(input reg_byte_t lower, input reg_byte_t upper, input prio_code_t code);
        reg_byte_t sel;
        sel = code[2] ? upper : lower;
        case (code[1:0])
            2'h0: map_field = sel[1:0];
            2'h1: map_field = sel[3:2];
            2'h2: map_field = sel[5:4];
            default: map_field = sel[7:6];
        endcase
    endfunction

    // Tag mapping, or the service result when that source is selected.
    always_comb
    begin
        tag_result = map_field(state_reg.lower_map_reg, state_reg.upper_map_reg, I_PRIO_CODE);
        chosen_result = I_USE_SERVICE ? I_SERVICE_RESULT : tag_result;
    end

    // Feed the reducer; configuration comes from the register, mode from the pin.
    assign rif.mapped_result = chosen_result;
    assign rif.two_queue_mode = I_TWO_QUEUE;
    assign rif.two_queue_threshold = state_reg.two_queue_threshold_reg;

    // Next-state logic: register writes, reads and the queue answer.
    always_comb
    begin
        state_next = state_reg;
        state_next.queue_valid_reg = I_FRAME_VALID;
        if (I_FRAME_VALID)
        begin
            state_next.queue_idx_reg = rif.queue_idx;
            state_next.mapped_prio_reg = chosen_result;
        end
        // A write in the same cycle as a frame only affects later frames.
        if (I_REG_WR)
        begin
            case (I_REG_ADDR)
                `LOWER_MAP_ADDR: state_next.lower_map_reg = I_REG_WDATA;
                `UPPER_MAP_ADDR: state_next.upper_map_reg = I_REG_WDATA;
                `THRESH_CTRL_ADDR: state_next.two_queue_threshold_reg = I_REG_WDATA[`THRESH_MSB:`THRESH_LSB];
                default: state_next.lower_map_reg = state_reg.lower_map_reg;
            endcase
        end
        if (I_REG_RD)
        begin
            case (I_REG_ADDR)
                `LOWER_MAP_ADDR: state_next.rdata_reg = state_reg.lower_map_reg;
                `UPPER_MAP_ADDR: state_next.rdata_reg = state_reg.upper_map_reg;
                `THRESH_CTRL_ADDR: state_next.rdata_reg = {state_reg.two_queue_threshold_reg, `THRESH_RSVD_VALUE};
                default: state_next.rdata_reg = `UNMAPPED_RDATA;
            endcase
        end
    end

    // State register; reset loads the documented defaults.
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
        begin
            state_reg.lower_map_reg <= `LOWER_MAP_RESET;
            state_reg.upper_map_reg <= `UPPER_MAP_RESET;
            state_reg.two_queue_threshold_reg <= `THRESH_RESET;
            state_reg.rdata_reg <= `UNMAPPED_RDATA;
            state_reg.queue_valid_reg <= 1'b0;
            state_reg.queue_idx_reg <= `QUEUE_LOW;
            state_reg.mapped_prio_reg <= `QUEUE_LOW;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    // Outputs come straight from the state flops.
    assign O_REG_RDATA = state_reg.rdata_reg;
    assign O_QUEUE_VALID = state_reg.queue_valid_reg;
    assign O_QUEUE_IDX = state_reg.queue_idx_reg;
    assign O_MAPPED_PRIO = state_reg.mapped_prio_reg;
endmodule
`default_nettype wire

// [logic/queue_reduce_if.sv]
// Carrier between the mapper top and its queue reducer.
`timescale 1ns/100ps
`default_nettype none
interface queue_reduce_if;
    import prio_map_pkg::*;

    prio2_t mapped_result;
    logic two_queue_mode;
    prio2_t two_queue_threshold;
    prio2_t queue_idx;

    // The mapper supplies the result and configuration.
    modport client (
        output mapped_result,
        output two_queue_mode,
        output two_queue_threshold,
        input queue_idx
    );

    // The reducer turns them into a queue index.
    modport reducer (
        input mapped_result,
        input two_queue_mode,
        input two_queue_threshold,
        output queue_idx
    );
endinterface
`default_nettype wire

// [logic/queue_reducer.sv]
// Combinational reduction of a 2-bit mapped priority to a queue index.
`timescale 1ns/100ps
`default_nettype none
`include "prio_map_params.svh"
module queue_reducer (
    queue_reduce_if.reducer rif // Result in, queue index out.
);
    import prio_map_pkg::*;

    // Decide whether a result goes to the high queue in two-queue mode.
    // Result 1 follows threshold bit 0 and result 2 threshold bit 1; the unsupported
    // setting 01 therefore still gives a defined answer (1 and 3 high).
    function automatic logic goes_high(input prio2_t res, input prio2_t thr);
        logic hi;
        hi = 1'b0;
        if (res == `RESULT_TOP)
        begin
            hi = 1'b1;
        end
        else if (res == `RESULT_ONE)
        begin
            hi = thr[0];
        end
        else if (res == `RESULT_TWO)
        begin
            hi = thr[1];
        end
        return hi;
    endfunction

    // Four queues take the result as is; two queues take low or high.
    always_comb
    begin
        if (rif.two_queue_mode)
        begin
            rif.queue_idx = goes_high(rif.mapped_result, rif.two_queue_threshold) ? `QUEUE_HIGH : `QUEUE_LOW;
        end
        else
        begin
            rif.queue_idx = rif.mapped_result;
        end
    end
endmodule
`default_nettype wire

// [testbench/prio_map_chk.sv]
// Port-level assertions for the priority tag queue mapper.
`timescale 1ns/100ps
`default_nettype none
`include "prio_map_params.svh"
module prio_map_chk (
    input wire logic I_CLOCK, // Clock.
    input wire logic I_RST_B, // Reset.
    input wire prio_map_pkg::reg_addr_t I_REG_ADDR, // Offset.
    input wire logic I_REG_WR, // Write.
    input wire prio_map_pkg::reg_byte_t I_REG_WDATA, // Data.
    input wire logic I_REG_RD, // Read.
    input wire logic [7:0] O_REG_RDATA, // Read data.
    input wire logic I_FRAME_VALID, // Request.
    input wire prio_map_pkg::prio_code_t I_PRIO_CODE, // Code.
    input wire logic I_USE_SERVICE, // Select.
    input wire prio_map_pkg::prio2_t I_SERVICE_RESULT, // Result.
    input wire logic I_TWO_QUEUE, // Mode.
    input wire logic O_QUEUE_VALID, // Valid.
    input wire logic [1:0] O_QUEUE_IDX, // Queue.
    input wire logic [1:0] O_MAPPED_PRIO // Mapped.
);
    import prio_map_pkg::*;
    prio2_t thr_reg;
    // Shadow the threshold from observed writes, since only ports are visible here.
    always_ff @(posedge I_CLOCK)
    begin
        if (!I_RST_B)
            thr_reg <= `THRESH_RESET;
        else if (I_REG_WR && I_REG_ADDR == `THRESH_CTRL_ADDR)
            thr_reg <= I_REG_WDATA[7:6];
    end
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);
    a_answer_next_cycle: assert property (I_FRAME_VALID |=> O_QUEUE_VALID) else $error("answer late");
    a_no_stray_answer: assert property (!I_FRAME_VALID |=> !O_QUEUE_VALID) else $error("stray answer");
    a_four_queue_direct: assert property (I_FRAME_VALID && !I_TWO_QUEUE |=> O_QUEUE_IDX == O_MAPPED_PRIO)
        else $error("four queue index");
    a_thresh_zero_split: assert property (I_FRAME_VALID && I_TWO_QUEUE && thr_reg == 2'h0
        |=> O_QUEUE_IDX == {1'b0, O_MAPPED_PRIO == 2'h3}) else $error("threshold 00 split");
    a_thresh_two_split: assert property (I_FRAME_VALID && I_TWO_QUEUE && thr_reg == 2'h2
        |=> O_QUEUE_IDX == {1'b0, O_MAPPED_PRIO[1]}) else $error("threshold 10 split");
    a_thresh_three_split: assert property (I_FRAME_VALID && I_TWO_QUEUE && thr_reg == 2'h3
        |=> O_QUEUE_IDX == {1'b0, O_MAPPED_PRIO != 2'h0}) else $error("threshold 11 split");
    a_rsvd_bits_fixed: assert property (I_REG_RD && I_REG_ADDR == `THRESH_CTRL_ADDR
        |=> O_REG_RDATA[5:0] == `THRESH_RSVD_VALUE) else $error("reserved bits moved");
    a_idx_holds_idle: assert property (!I_FRAME_VALID |=> $stable(O_QUEUE_IDX)) else $error("index moved");
    a_prio_holds_idle: assert property (!I_FRAME_VALID |=> $stable(O_MAPPED_PRIO)) else $error("prio moved");
    c_two_queue: cover property (I_FRAME_VALID && I_TWO_QUEUE);
    c_service: cover property (I_FRAME_VALID && I_USE_SERVICE);
    c_thresh_write: cover property (I_REG_WR && I_REG_ADDR == `THRESH_CTRL_ADDR);
endmodule
bind priority_tag_queue_mapper prio_map_chk u_chk (.I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WR(I_REG_WR), .I_REG_WDATA(I_REG_WDATA), .I_REG_RD(I_REG_RD), .O_REG_RDATA(O_REG_RDATA),
    .I_FRAME_VALID(I_FRAME_VALID), .I_PRIO_CODE(I_PRIO_CODE), .I_USE_SERVICE(I_USE_SERVICE),
    .I_SERVICE_RESULT(I_SERVICE_RESULT), .I_TWO_QUEUE(I_TWO_QUEUE), .O_QUEUE_VALID(O_QUEUE_VALID),
    .O_QUEUE_IDX(O_QUEUE_IDX), .O_MAPPED_PRIO(O_MAPPED_PRIO));
`default_nettype wire

// [testbench/tb_priority_tag_queue_mapper.sv]
// Self-checking bench for the priority tag queue mapper.
`timescale 1ns/100ps
`default_nettype none
`include "prio_map_params.svh"
module tb_priority_tag_queue_mapper;
    import prio_map_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic fv = 1'b0;
    logic use_svc = 1'b0;
    logic two_q = 1'b0;
    reg_addr_t addr = 8'h00;
    reg_byte_t wdata = 8'h00;
    prio_code_t code = 3'h0;
    prio2_t sres = 2'h0;
    logic [7:0] rdata;
    logic qv;
    logic [1:0] qidx;
    logic [1:0] mprio;
    logic [15:0] map;
    logic hi;
    int bad_count = 0;
    int comparisons = 0;
    priority_tag_queue_mapper DUT (.I_CLOCK(clk), .I_RST_B(rst_b), .I_REG_ADDR(addr), .I_REG_WR(wr),
        .I_REG_WDATA(wdata), .I_REG_RD(rd), .O_REG_RDATA(rdata), .I_FRAME_VALID(fv), .I_PRIO_CODE(code),
        .I_USE_SERVICE(use_svc), .I_SERVICE_RESULT(sres), .I_TWO_QUEUE(two_q), .O_QUEUE_VALID(qv),
        .O_QUEUE_IDX(qidx), .O_MAPPED_PRIO(mprio));
    initial forever #2.5 clk = ~clk;
    // Compare a settled output with its expectation; case inequality lets no unknown pass.
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Strobes drop a cycle before the next call raises them, so no signal changes twice in a step.
    task automatic reg_write(input reg_addr_t a, input reg_byte_t d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask
    task automatic reg_read(input reg_addr_t a, input reg_byte_t exp);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        check(rdata, exp);
    endtask
    task automatic frame(input prio_code_t c, input logic s, input prio2_t r, input logic t, input prio2_t ei,
        input prio2_t ep);
        @(negedge clk);
        {code, use_svc, sres, two_q, fv} = {c, s, r, t, 1'b1};
        @(negedge clk);
        fv = 1'b0;
        check({7'h00, qv}, 8'h01);
        check({6'h00, qidx}, {6'h00, ei});
        check({6'h00, mprio}, {6'h00, ep});
    endtask
    task automatic give_verdict;
        $display("bad_count %0d comparisons %0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // The run needs about 125 cycles; this bound only catches a hang.
    initial
    begin
        #20000;
        bad_count++;
        give_verdict();
    end
    initial
    begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        reg_read(`LOWER_MAP_ADDR, 8'h50);
        reg_read(`UPPER_MAP_ADDR, 8'hfa);
        reg_read(`THRESH_CTRL_ADDR, 8'h84);
        reg_read(8'h83, `UNMAPPED_RDATA);
        map = 16'hfa50;
        for (int p = 0; p < 2; p++)
        begin
            for (int c = 0; c < 8; c++)
                frame(c[2:0], 1'b0, 2'h0, 1'b0, map[2*c +: 2], map[2*c +: 2]);
            map = 16'h1be4;
            reg_write(`LOWER_MAP_ADDR, map[7:0]);
            reg_write(`UPPER_MAP_ADDR, map[15:8]);
        end
        reg_read(`LOWER_MAP_ADDR, 8'he4);
        reg_read(`UPPER_MAP_ADDR, 8'h1b);
        for (int t = 0; t < 4; t++)
        begin
            if (t != 1)
            begin
                reg_write(`THRESH_CTRL_ADDR, {t[1:0], 6'h3f});
                reg_read(`THRESH_CTRL_ADDR, {t[1:0], 6'h04});
                for (int r = 0; r < 4; r++)
                begin
                    hi = (t == 0) ? (r == 3) : (t == 2) ? (r >= 2) : (r != 0);
                    frame(r[2:0], 1'b0, 2'h0, 1'b1, {1'b0, hi}, r[1:0]);
                    frame(3'h7, 1'b1, r[1:0], 1'b1, {1'b0, hi}, r[1:0]);
                end
            end
        end
        give_verdict();
    end
endmodule
`default_nettype wire
